// file: design/pot_cmd_pkg.sv
// Overview of operation
// R01: opcode 0 leaves wipers, clears read-program state
// R02: opcode 1 restores stored word into wiper
// R03: opcode 2 saves wiper into stored word
// R04: opcode 3 writes sixteen data bits to memory
// R05: memory words 0 and 1 keep ten bits
// R06: opcode 4 halves one wiper, floor zero
// R07: opcode 5 halves both wipers, floor zero
// R08: opcode 6 decrements one wiper, saturating
// R09: opcode 7 decrements both wipers, saturating
// R10: opcode 8 reloads every wiper from memory
// R11: opcode 9 reads memory word next frame
// R12: opcode 10 reads wiper value next frame
// R13: opcode 11 loads ten data bits to wiper
// R14: opcode 12 doubles one wiper, ceiling ones
// R15: opcode 13 doubles both wipers, ceiling ones
// R16: opcode 14 increments one wiper, saturating
// R17: opcode 15 increments both wipers, saturating
// R18: serial output repeats last 24 bits in
// R19: readback fills data bytes of next frame
// R20: commands execute only on chip select rise
// R21: step and shift opcodes ignore data bytes
// R22: host sends 24 bits msb first
// R23: bit count not a multiple of four discards frame, clears counter
// R24: bare chip select pulse repeats last command
// R25: memory commands wait while write busy
//
package pot_cmd_pkg;

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 24;
  localparam int CNT_BITS = 5;
  localparam int OPCODE_MSB = 23;
  localparam int OPCODE_LSB = 20;
  localparam int ADDR_MSB = 19;
  localparam int ADDR_LSB = 16;
  localparam int CHANNEL_BIT = 16;
  localparam int DATA_MSB = 15;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  localparam int WIPER_BITS = 10;
  localparam int NV_WIDTH = 16;
  localparam int NV_WORDS = 16;
  localparam int NV_ADDR_BITS = 4;
  localparam logic [3:0] NV_FACTORY_ADDR = 4'hF;
  localparam logic [15:0] NV_RESET_WORD = 16'h0000;
  // arbitrary neutral value for the factory word
  localparam logic [15:0] NV_FACTORY_WORD = 16'h0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLOCK_MHZ = 40;
  localparam int NV_WRITE_US = 50;
  localparam int NV_WRITE_CYCLES = NV_WRITE_US * CLOCK_MHZ;
  localparam int SYNC_STAGES = 3;

  typedef enum logic [3:0] {
    OP_NOP, OP_RESTORE, OP_STORE, OP_NV_WRITE,
    OP_SHR_ONE, OP_SHR_ALL, OP_DEC_ONE, OP_DEC_ALL,
    OP_REFRESH, OP_READ_NV, OP_READ_WIPER, OP_WRITE_WIPER,
    OP_SHL_ONE, OP_SHL_ALL, OP_INC_ONE, OP_INC_ALL
  } opcode_type;

  typedef enum logic [1:0] {
    ST_POWERUP, ST_IDLE, ST_WAIT, ST_EXEC
  } exec_state_type;

endpackage : pot_cmd_pkg

// file: design/nv_word_store.sv
`timescale 1ns/1ps
module nv_word_store #(
  parameter int WIDTH = pot_cmd_pkg::NV_WIDTH,
  parameter int DEPTH = pot_cmd_pkg::NV_WORDS,
  parameter int WRITE_CYCLES = pot_cmd_pkg::NV_WRITE_CYCLES
) (
  input wire logic clock,
  input wire logic rstN,
  input wire logic wrEn,
  input wire logic [pot_cmd_pkg::NV_ADDR_BITS-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic [pot_cmd_pkg::NV_ADDR_BITS-1:0] rdAddr,
  output logic [WIDTH-1:0] rdData,
  output logic [WIDTH-1:0] wiperWord0,
  output logic [WIDTH-1:0] wiperWord1,
  output logic busy
);
  import pot_cmd_pkg::*;

  localparam int TW = $clog2(WRITE_CYCLES + 1);
  localparam logic [TW-1:0] WRITE_LOAD = TW'(WRITE_CYCLES);

  if (DEPTH < 2 || DEPTH > NV_WORDS || WIDTH != NV_WIDTH
      || WRITE_CYCLES < 1) begin : g_bad
    $error("nv_word_store: unsupported parameters");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [TW-1:0] timer_r;

  // ----------------------------------------------------------------
  // word array; the factory word is read only
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= (i == int'(NV_FACTORY_ADDR)) ? NV_FACTORY_WORD
                                                : NV_RESET_WORD;
      end
    end else if (wrEn && !busy && wrAddr != NV_FACTORY_ADDR
                 && int'(wrAddr) < DEPTH) begin
      mem_r[wrAddr] <= wrData;
    end
  end

  // ----------------------------------------------------------------
  // write time model
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      timer_r <= '0;
    end else if (wrEn && !busy) begin
      timer_r <= WRITE_LOAD;
    end else if (timer_r != '0) begin
      timer_r <= timer_r - 1'b1;
    end
  end

  assign busy = (timer_r != '0);
  assign rdData = (int'(rdAddr) < DEPTH) ? mem_r[rdAddr] : '0;
  assign wiperWord0 = mem_r[0];
  assign wiperWord1 = mem_r[1];

endmodule : nv_word_store

// file: design/dual_wiper_command_decoder.sv
`timescale 1ns/1ps
module dual_wiper_command_decoder #(
  parameter int W = pot_cmd_pkg::WIPER_BITS,
  parameter int WRITE_CYCLES = pot_cmd_pkg::NV_WRITE_CYCLES
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic csN,
  output logic sdoOut,
  output logic sdoOe,
  output logic [W-1:0] wiper0,
  output logic [W-1:0] wiper1,
  output logic nvBusy,
  output logic readProgState
);
  import pot_cmd_pkg::*;

  if (W < 2 || W > NV_WIDTH) begin : g_bad
    $error("dual_wiper_command_decoder: unsupported wiper width");
  end

  localparam logic [W-1:0] MAXV = '1;
  localparam logic [W-1:0] MIDV = {1'b1, {(W-1){1'b0}}};
  localparam logic [NV_WIDTH-1:0] WIPER_MASK = NV_WIDTH'(MAXV);
  localparam logic [CNT_BITS-1:0] LAST_BIT = CNT_BITS'(FRAME_BITS - 1);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [W-1:0] stepValue(opcode_type op,
                                             logic [W-1:0] v);
    logic [W-1:0] r;
    r = v;
    case (op)
      OP_SHR_ONE, OP_SHR_ALL: r = v >> 1; // R06 R07
      OP_DEC_ONE, OP_DEC_ALL: r = (v == '0) ? v : v - 1'b1; // R08 R09
      OP_SHL_ONE, OP_SHL_ALL: begin // R14 R15
        if (v == '0) r = W'(1);
        else if (v >= MIDV) r = MAXV;
        else r = v << 1;
      end
      OP_INC_ONE, OP_INC_ALL: r = (v == MAXV) ? v : v + 1'b1; // R16 R17
      default: r = v;
    endcase
    return r;
  endfunction : stepValue

  function automatic logic hitsChannel(opcode_type op, logic sel,
                                       logic idx);
    logic h;
    h = 1'b0;
    case (op)
      OP_SHR_ALL, OP_DEC_ALL, OP_SHL_ALL, OP_INC_ALL: h = 1'b1;
      OP_SHR_ONE, OP_DEC_ONE, OP_SHL_ONE, OP_INC_ONE: h = (sel == idx);
      default: h = 1'b0;
    endcase
    return h;
  endfunction : hitsChannel

  function automatic logic usesMemory(opcode_type op);
    return op == OP_RESTORE || op == OP_STORE || op == OP_NV_WRITE
        || op == OP_REFRESH || op == OP_READ_NV;
  endfunction : usesMemory

  // ----------------------------------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rstSync_r;
  logic rstN;
  logic [SYNC_STAGES-1:0] sclkS_r, sdiS_r, csS_r;
  logic sclkF_r, sdiF_r, csF_r, sclkP_r, csP_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) rstSync_r <= 2'h0;
    else rstSync_r <= {rstSync_r[0], 1'b1};
  end
  assign rstN = rstSync_r[1];

  // a level only counts once stages two and three agree
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      sclkS_r <= '0;
      sdiS_r <= '0;
      csS_r <= '1;
      sclkF_r <= 1'b0;
      sdiF_r <= 1'b0;
      csF_r <= 1'b1;
      sclkP_r <= 1'b0;
      csP_r <= 1'b1;
    end else begin
      sclkS_r <= {sclkS_r[1:0], sclk};
      sdiS_r <= {sdiS_r[1:0], sdi};
      csS_r <= {csS_r[1:0], csN};
      if (sclkS_r[1] == sclkS_r[2]) sclkF_r <= sclkS_r[2];
      if (sdiS_r[1] == sdiS_r[2]) sdiF_r <= sdiS_r[2];
      if (csS_r[1] == csS_r[2]) csF_r <= csS_r[2];
      sclkP_r <= sclkF_r;
      csP_r <= csF_r;
    end
  end

  logic sclkRise, sclkFall, csFall, csRise, selected;
  assign sclkRise = sclkF_r & ~sclkP_r;
  assign sclkFall = ~sclkF_r & sclkP_r;
  assign csFall = ~csF_r & csP_r;
  assign csRise = csF_r & ~csP_r;
  assign selected = ~csF_r;

  // ----------------------------------------------------------------
  // serial shift path
  // ----------------------------------------------------------------
  logic [FRAME_BITS-1:0] shift_r;
  logic [CNT_BITS-1:0] bitCnt_r;
  logic anyBits_r, sdoBit_r, readPending_r;
  logic [NV_WIDTH-1:0] readVal_r;
  exec_state_type state_r;
  logic [FRAME_BITS-1:0] cmd_r;
  logic haveCmd_r;
  logic accept, repeatCmd;
  opcode_type op;
  logic sel;

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      shift_r <= '0;
    end else if (csFall && readPending_r) begin
      shift_r[DATA_MSB:0] <= readVal_r; // R19
    end else if (sclkRise && selected) begin
      shift_r <= {shift_r[FRAME_BITS-2:0], sdiF_r}; // R22
    end
  end

  // bit leaving the top is the bit seen 24 clocks earlier
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      sdoBit_r <= 1'b1;
    end else if (csFall || (sclkFall && selected)) begin
      sdoBit_r <= shift_r[FRAME_BITS-1]; // R18
    end
  end

  assign sdoOut = 1'b0;
  assign sdoOe = selected & ~sdoBit_r;

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      bitCnt_r <= '0;
      anyBits_r <= 1'b0;
    end else if (csFall || (csRise && bitCnt_r[1:0] != 2'h0)) begin
      bitCnt_r <= '0; // R23
      anyBits_r <= 1'b0;
    end else if (sclkRise && selected) begin
      bitCnt_r <= (bitCnt_r == LAST_BIT) ? '0 : bitCnt_r + 1'b1;
      anyBits_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // command capture and execution
  // ----------------------------------------------------------------
  assign accept = csRise && anyBits_r && bitCnt_r[1:0] == 2'h0; // R20
  assign repeatCmd = csRise && !anyBits_r && haveCmd_r; // R24
  assign op = opcode_type'(cmd_r[OPCODE_MSB:OPCODE_LSB]);
  assign sel = cmd_r[CHANNEL_BIT];

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      cmd_r <= '0;
      haveCmd_r <= 1'b0;
    end else if (accept && state_r != ST_POWERUP) begin
      cmd_r <= shift_r;
      haveCmd_r <= 1'b1;
    end
  end

  logic memBusy;

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      state_r <= ST_POWERUP;
    end else begin
      case (state_r)
        ST_POWERUP: if (!memBusy) state_r <= ST_IDLE;
        ST_IDLE: if (accept || repeatCmd) state_r <= ST_WAIT;
        ST_WAIT: if (!(usesMemory(op) && memBusy)) state_r <= ST_EXEC; // R25
        ST_EXEC: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  logic execNow;
  assign execNow = (state_r == ST_EXEC);

  // ----------------------------------------------------------------
  // memory port
  // ----------------------------------------------------------------
  logic memWrEn;
  logic [NV_ADDR_BITS-1:0] memWrAddr;
  logic [NV_WIDTH-1:0] memWrData, memRdData, memWord0, memWord1;
  logic [W-1:0] selWiper;

  assign selWiper = sel ? wiper1 : wiper0;
  assign memWrEn = execNow && (op == OP_STORE || op == OP_NV_WRITE);
  always_comb begin
    memWrAddr = cmd_r[ADDR_MSB:ADDR_LSB];
    memWrData = cmd_r[DATA_MSB:0]; // R04
    if (op == OP_STORE) begin
      memWrAddr = {3'h0, sel};
      memWrData = NV_WIDTH'(selWiper); // R03
    end else if (memWrAddr[NV_ADDR_BITS-1:1] == 3'h0) begin
      memWrData = cmd_r[DATA_MSB:0] & WIPER_MASK; // R05
    end
  end

  nv_word_store #(
    .WIDTH(NV_WIDTH),
    .DEPTH(NV_WORDS),
    .WRITE_CYCLES(WRITE_CYCLES)
  ) u_store (
    .clock(clock),
    .rstN(rstN),
    .wrEn(memWrEn),
    .wrAddr(memWrAddr),
    .wrData(memWrData),
    .rdAddr(cmd_r[ADDR_MSB:ADDR_LSB]),
    .rdData(memRdData),
    .wiperWord0(memWord0),
    .wiperWord1(memWord1),
    .busy(memBusy)
  );
  assign nvBusy = memBusy;

  // ----------------------------------------------------------------
  // wiper registers; step opcodes never look at data bytes
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      wiper0 <= '0;
      wiper1 <= '0;
    end else if (state_r == ST_POWERUP && !memBusy) begin
      wiper0 <= memWord0[W-1:0];
      wiper1 <= memWord1[W-1:0];
    end else if (execNow) begin
      case (op)
        OP_RESTORE: begin // R02
          if (!sel) wiper0 <= memWord0[W-1:0];
          else wiper1 <= memWord1[W-1:0];
        end
        OP_REFRESH: begin // R10
          wiper0 <= memWord0[W-1:0];
          wiper1 <= memWord1[W-1:0];
        end
        OP_WRITE_WIPER: begin // R13
          if (!sel) wiper0 <= cmd_r[W-1:0];
          else wiper1 <= cmd_r[W-1:0];
        end
        default: begin // R21
          if (hitsChannel(op, sel, 1'b0)) wiper0 <= stepValue(op, wiper0);
          if (hitsChannel(op, sel, 1'b1)) wiper1 <= stepValue(op, wiper1);
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // readback and power state
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      readVal_r <= '0;
      readPending_r <= 1'b0;
    end else if (execNow && op == OP_READ_NV) begin
      readVal_r <= memRdData; // R11
      readPending_r <= 1'b1;
    end else if (execNow && op == OP_READ_WIPER) begin
      readVal_r <= NV_WIDTH'(selWiper); // R12
      readPending_r <= 1'b1;
    end else if (csFall) begin
      readPending_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) readProgState <= 1'b0;
    else if (execNow && op == OP_RESTORE) readProgState <= 1'b1;
    else if (execNow && op == OP_NOP) readProgState <= 1'b0; // R01
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstN);

  a_exec_after_cs: assert property ($rose(state_r == ST_WAIT) // R20
    |-> $past(csRise)) else $error("command started without cs rise");
  a_nop_holds: assert property (execNow && op == OP_NOP // R01
    |=> $stable(wiper0) && $stable(wiper1) && !readProgState)
    else $error("nop changed state");
  a_restore_state: assert property (execNow && op == OP_RESTORE // R02
    |=> readProgState) else $error("restore missed power state");
  a_shr_one: assert property (execNow && op == OP_SHR_ONE && !sel // R06
    |=> wiper0 == ($past(wiper0) >> 1)) else $error("bad right shift");
  a_dec_floor: assert property (execNow && op == OP_DEC_ALL // R09
    && wiper1 == '0 |=> wiper1 == '0) else $error("decrement wrapped");
  a_inc_step: assert property (execNow && op == OP_INC_ONE && !sel // R16
    && wiper0 != MAXV |=> wiper0 == $past(wiper0) + 1'b1)
    else $error("bad increment");
  a_wiper_load: assert property (execNow && op == OP_WRITE_WIPER // R13
    && sel |=> wiper1 == $past(cmd_r[W-1:0])) else $error("bad load");
  a_read_pending: assert property (execNow && op == OP_READ_WIPER // R12
    |=> readPending_r ##0 readVal_r == NV_WIDTH'($past(selWiper)))
    else $error("readback not armed");
  a_discard_odd: assert property (csRise && anyBits_r // R23
    && bitCnt_r[1:0] != 2'h0 |=> bitCnt_r == '0 && !anyBits_r)
    else $error("odd frame not discarded");
  a_defer_busy: assert property (state_r == ST_WAIT && memBusy // R25
    && usesMemory(op) |=> state_r == ST_WAIT) else $error("not deferred");
  a_store_busy: assert property (execNow && op == OP_STORE // R03
    |=> memBusy) else $error("store did not start a write");
  a_mask_low: assert property (memWrEn // R05
    && memWrAddr[NV_ADDR_BITS-1:1] == 3'h0
    |-> (memWrData & ~WIPER_MASK) == '0) else $error("wiper word unmasked");
  a_refresh_both: assert property (execNow && op == OP_REFRESH // R10
    |=> wiper0 == $past(memWord0[W-1:0])
    && wiper1 == $past(memWord1[W-1:0])) else $error("refresh missed");
  a_shl_ceiling: assert property (execNow && op == OP_SHL_ALL // R15
    && wiper0 >= MIDV |=> wiper0 == MAXV) else $error("left shift overflow");
  a_repeat_start: assert property (repeatCmd && state_r == ST_IDLE // R24
    |=> state_r == ST_WAIT) else $error("repeat not started");

  // ----------------------------------------------------------------
  // scenario covers
  // ----------------------------------------------------------------
  c_readback: cover property (execNow && op == OP_READ_NV ##[1:300] csFall);
  c_repeat: cover property (repeatCmd);
  // deferral shows whenever a memory command arrives during a write
  c_deferred: cover property (state_r == ST_WAIT && memBusy);
  c_discard: cover property (csRise && anyBits_r && bitCnt_r[1:0] != 2'h0);
  c_store: cover property (memWrEn);

endmodule : dual_wiper_command_decoder

// file: dv/host_serial_master.sv
`timescale 1ns/1ps
module host_serial_master #(
  parameter int HALF = 6
) (
  input wire logic clock,
  input wire logic sdoLine,
  output logic sclk,
  output logic sdi,
  output logic csN
);
  // ------------------------------------------------------------
  // serial master, mode 0: sclk rests low outside frames
  // ------------------------------------------------------------
  logic [23:0] lastRead;

  initial begin
    sclk = 1'b0;
    sdi = 1'b0;
    csN = 1'b1;
    lastRead = 24'h000000;
  end

  task automatic wait_clocks(input int n);
    repeat (n) @(negedge clock);
  endtask : wait_clocks

  task automatic cs_low();
    csN = 1'b0;
    wait_clocks(HALF);
  endtask : cs_low

  // msb first; levels held HALF clocks so the pin filter settles
  task automatic shift_bits(input logic [23:0] word, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      sdi = word[i];
      wait_clocks(HALF);
      lastRead = {lastRead[22:0], sdoLine};
      sclk = 1'b1;
      wait_clocks(HALF);
      sclk = 1'b0;
    end
  endtask : shift_bits

  task automatic cs_high();
    wait_clocks(HALF);
    csN = 1'b1;
    wait_clocks(2 * HALF);
  endtask : cs_high

  // whole 24-bit frame, also used to clock out readback data
  task automatic send(input logic [23:0] word);
    cs_low();
    shift_bits(word, 24);
    cs_high();
  endtask : send

endmodule : host_serial_master

// file: dv/dual_wiper_command_decoder_tb_top.sv
`timescale 1ns/1ps
module dual_wiper_command_decoder_tb_top;
  import pot_cmd_pkg::*;
  localparam int WCYC = 40;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic sclk, sdi, csN, sdoOut, sdoOe, nvBusy, readProgState;
  logic [9:0] wiper0, wiper1;
  logic [9:0] exp0, exp1;
  logic sdoLine;
  int miscompares = 0;
  int compares = 0;

  // open-drain output with a pull-up on the line
  assign sdoLine = (sdoOe === 1'b1) ? sdoOut : 1'b1;

  always #12.5 clock = ~clock;

  dual_wiper_command_decoder #(.W(10), .WRITE_CYCLES(WCYC)) i_dut (
    .clock(clock), .nrst(nrst), .sclk(sclk), .sdi(sdi), .csN(csN),
    .sdoOut(sdoOut), .sdoOe(sdoOe), .wiper0(wiper0), .wiper1(wiper1),
    .nvBusy(nvBusy), .readProgState(readProgState));

  host_serial_master #(.HALF(6)) i_host (
    .clock(clock), .sdoLine(sdoLine), .sclk(sclk), .sdi(sdi), .csN(csN));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic report_and_stop();
    if (miscompares == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [23:0] seen,
                       input logic [23:0] expected);
    compares++;
    if (seen !== expected) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, expected, seen);
    end
  endtask : check

  task automatic check_wipers();
    check("wiper0", {14'h0, wiper0}, {14'h0, exp0});
    check("wiper1", {14'h0, wiper1}, {14'h0, exp1});
  endtask : check_wipers

  // bounded wait for a memory write to finish
  task automatic frame(input logic [3:0] op, input logic [3:0] addr,
                       input logic [15:0] data);
    i_host.send({op, addr, data});
    for (int i = 0; i < 200 && nvBusy !== 1'b0; i++) @(negedge clock);
    check("nvBusy", {23'h0, nvBusy}, 24'h0);
  endtask : frame

  function automatic logic [9:0] step(input logic [3:0] op,
                                      input logic [9:0] v);
    case (op)
      4'h4, 4'h5: step = v >> 1;
      4'h6, 4'h7: step = (v == 10'h000) ? v : v - 10'h001;
      4'hC, 4'hD: step = (v == 10'h000) ? 10'h001 :
                         (v >= 10'h200) ? 10'h3FF : v << 1;
      default: step = (v == 10'h3FF) ? v : v + 10'h001;
    endcase
  endfunction : step

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic write_wiper_deferred();
    i_host.cs_low();
    i_host.shift_bits({OP_WRITE_WIPER, 4'h0, 16'hFEAA}, 24);
    check("wiper0 mid", {14'h0, wiper0}, {14'h0, exp0});
    i_host.cs_high();
    exp0 = 10'h2AA;
    check_wipers();
  endtask : write_wiper_deferred

  task automatic step_ops();
    logic [7:0] tbl [16];
    logic [3:0] op;
    tbl = '{8'hE0, 8'hE0, 8'h61, 8'h61, 8'hFA, 8'h7A, 8'hC1, 8'hDA,
            8'h40, 8'h5A, 8'hC0, 8'hC0, 8'hC0, 8'h41, 8'h41, 8'h5A};
    frame(OP_WRITE_WIPER, 4'h0, 16'hFBFE);
    frame(OP_WRITE_WIPER, 4'h1, 16'hFC01);
    exp0 = 10'h3FE;
    exp1 = 10'h001;
    check_wipers();
    foreach (tbl[k]) begin
      op = tbl[k][7:4];
      // data bytes hold a pattern that must not leak in
      frame(op, tbl[k][3:0], 16'hA5A5);
      if (op[0] || !tbl[k][0]) exp0 = step(op, exp0);
      if (op[0] || tbl[k][0]) exp1 = step(op, exp1);
      check_wipers();
    end
  endtask : step_ops

  task automatic repeat_and_discard();
    i_host.cs_low();
    i_host.cs_high();
    exp0 = step(4'h5, exp0);
    exp1 = step(4'h5, exp1);
    check_wipers();
    i_host.cs_low();
    i_host.shift_bits({OP_WRITE_WIPER, 4'h0, 16'h0123}, 22);
    i_host.cs_high();
    check_wipers();
    frame(OP_WRITE_WIPER, 4'h1, 16'h0155);
    exp1 = 10'h155;
    check_wipers();
  endtask : repeat_and_discard

  task automatic readback();
    logic [23:0] got;
    i_host.send({OP_NV_WRITE, 4'h5, 16'hA5C3});
    check("busy after write", {23'h0, nvBusy}, 24'h1);
    // a bare pulse repeats the write, which must wait for the first
    i_host.cs_low();
    i_host.cs_high();
    repeat (20) @(negedge clock);
    check("busy deferred", {23'h0, nvBusy}, 24'h1);
    frame(OP_NOP, 4'h0, 16'h0000);
    frame(OP_READ_NV, 4'h5, 16'h0000);
    frame(OP_NOP, 4'h0, 16'h1234);
    got = {8'h0, i_host.lastRead[15:0]};
    check("nv readback", got, 24'h00A5C3);
    frame(OP_NOP, 4'h0, 16'h0000);
    check("echo", i_host.lastRead, 24'h001234);
    frame(OP_READ_WIPER, 4'h1, 16'h0000);
    frame(OP_NOP, 4'h0, 16'h0000);
    got = {8'h0, i_host.lastRead[15:0]};
    check("wiper readback", got, {14'h0, exp1});
  endtask : readback

  task automatic reset_midrun();
    frame(OP_RESTORE, 4'h0, 16'h0000);
    check("readProg armed", {23'h0, readProgState}, 24'h1);
    nrst = 1'b0;
    repeat (2) @(negedge clock);
    nrst = 1'b1;
    repeat (12) @(negedge clock);
    exp0 = 10'h000;
    exp1 = 10'h000;
    check_wipers();
    check("readProg reset", {23'h0, readProgState}, 24'h0);
    // no command is remembered across reset, so nothing repeats
    i_host.cs_low();
    i_host.cs_high();
    check_wipers();
    frame(OP_INC_ALL, 4'h0, 16'h0000);
    exp0 = 10'h001;
    exp1 = 10'h001;
    check_wipers();
  endtask : reset_midrun

  task automatic store_restore();
    frame(OP_STORE, 4'h0, 16'h0000);
    frame(OP_WRITE_WIPER, 4'h0, 16'h0055);
    frame(OP_RESTORE, 4'h0, 16'h0000);
    check_wipers();
    check("readProg set", {23'h0, readProgState}, 24'h1);
    frame(OP_NOP, 4'hF, 16'hFFFF);
    check("readProg clear", {23'h0, readProgState}, 24'h0);
    check_wipers();
    frame(OP_NV_WRITE, 4'h1, 16'hFFFF);
    frame(OP_REFRESH, 4'h0, 16'h0000);
    exp1 = 10'h3FF;
    check_wipers();
  endtask : store_restore

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    exp0 = 10'h000;
    exp1 = 10'h000;
    repeat (4) @(negedge clock);
    nrst = 1'b1;
    repeat (12) @(negedge clock);
    check_wipers();
    check("sdoOe idle", {23'h0, sdoOe}, 24'h0);
    write_wiper_deferred();
    store_restore();
    step_ops();
    repeat_and_discard();
    readback();
    reset_midrun();
    report_and_stop();
  end

  // about 40 frames of some 320 clocks each, doubled for margin
  initial begin
    repeat (30000) @(posedge clock);
    miscompares++;
    report_and_stop();
  end

endmodule : dual_wiper_command_decoder_tb_top
